// [dv/uart_rx_error_status_test.sv]
module uart_rx_error_status_test
    import ures_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // clock, reset, bus
    logic              clk;
    logic              rst;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [3:0]        avs_byteenable;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    // serial line and interrupts
    logic              rxd;
    logic              rx_error_irq;
    logic              rx_complete_irq;
    logic              irq;
    // bookkeeping
    int                fails;
    int                tests_run;
    int                cycles;
    int                n_err;
    int                n_cmp;
    logic [31:0]       seed;
    logic [31:0]       rd;

    ures_top uut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd(rxd),
        .rx_error_irq(rx_error_irq), .rx_complete_irq(rx_complete_irq), .irq(irq));
    ures_uart_tx tx (.clk(clk), .rxd(rxd));

    // *******************
    // helpers
    // *******************
    initial clk = 1'b0;
    always #50 clk = ~clk;
    // interrupt pulse counters and hang guard
    always @(posedge clk) begin
        if (rx_error_irq === 1'b1) n_err++;
        if (rx_complete_irq === 1'b1) n_cmp++;
        cycles++;
        if (cycles == 30000) begin
            fails++;
            stop_test;
        end
    end
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : next_rand
    // mode register image
    function automatic logic [31:0] mode_val(input logic re, input logic [1:0] pm, input logic l8,
                                             input logic sel);
        logic [7:0] m;
        m = MODE_RST;
        m[MODE_UNIT_EN] = 1'b1;
        m[MODE_RX_EN] = re;
        m[MODE_PAR_HI] = pm[1];
        m[MODE_PAR_LO] = pm[0];
        m[MODE_LEN8] = l8;
        m[MODE_IRQ_SEL] = sel;
        return {24'h0, m};
    endfunction : mode_val
    // flags expected after one frame
    function automatic logic [31:0] exp_err(input logic [1:0] pm, input logic bp, input logic bs);
        logic [31:0] e;
        e = 32'h0;
        e[ERR_PARITY] = bp & (pm != PAR_NONE);
        e[ERR_FRAMING] = bs;
        return e;
    endfunction : exp_err
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic rdchk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(nm, e, q);
    endtask : rdchk
    task automatic irqchk(input logic e);
        @(negedge clk);
        check("irq", {31'h0, e}, {31'h0, irq});
    endtask : irqchk
    // receiver off then on, so the select bit may change
    task automatic set_mode(input logic [1:0] pm, input logic l8, input logic sel);
        bus(1'b1, OFS_MODE, mode_val(1'b0, pm, l8, sel), rd);
        bus(1'b1, OFS_MODE, mode_val(1'b1, pm, l8, sel), rd);
    endtask : set_mode
    // send a frame, check pulses, flags, read clear, buffer
    task automatic frame_chk(input logic [7:0] d, input logic l8, input logic [1:0] pm,
                             input logic sel, input logic bp, input logic bs);
        int          e0;
        int          c0;
        logic [31:0] ee;
        ee = exp_err(pm, bp, bs);
        e0 = n_err;
        c0 = n_cmp;
        set_mode(pm, l8, sel);
        tx.send_frame(d, l8, pm, bp, bs);
        check("err_pulses", ((ee != 32'h0) && !sel) ? e0 + 1 : e0, n_err);
        check("cmp_pulses", ((ee != 32'h0) && !sel) ? c0 : c0 + 1, n_cmp);
        rdchk("rx_error_status", OFS_ERR, ee);
        rdchk("rx_error_status", OFS_ERR, 32'h0);
        rdchk("rx_data_buffer", OFS_DATA, l8 ? {24'h0, d} : {25'h0, d[6:0]});
    endtask : frame_chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // *******************
    // main sequence
    // *******************
    initial begin
        rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        seed = 32'h20BC5FD0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdchk("rx_error_status", OFS_ERR, 32'h0);
        bus(1'b1, OFS_ERR, 32'h000000FF, rd);
        rdchk("rx_error_status", OFS_ERR, 32'h0);
        rdchk("unmapped", 5'h18, 32'h0);
        rdchk("baud_divisor", OFS_BAUD, {16'h0, BAUD_RST});
        bus(1'b1, OFS_BAUD, 32'h0, rd);
        rdchk("baud_divisor", OFS_BAUD, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            seed = next_rand(seed);
            frame_chk(seed[7:0], 1'b1, i[2:1], i[0], i[0], 1'b0);
        end
        frame_chk(8'h5A, 1'b0, PAR_EVEN, 1'b0, 1'b0, 1'b1);
        $display("test parity_framing done");
        repeat (12) begin
            seed = next_rand(seed);
            frame_chk(seed[7:0], seed[8], seed[10:9], seed[11], seed[12], seed[13]);
        end
        $display("test random_frames done");
        set_mode(PAR_NONE, 1'b1, 1'b0);
        bus(1'b1, OFS_IRQ_STAT, 32'h3, rd);
        tx.send_frame(8'hA5, 1'b1, PAR_NONE, 1'b0, 1'b0);
        tx.send_frame(8'h3C, 1'b1, PAR_NONE, 1'b0, 1'b0);
        rdchk("rx_error_status", OFS_ERR, 32'h1);
        rdchk("rx_data_buffer", OFS_DATA, 32'hA5);
        rdchk("irq_status", OFS_IRQ_STAT, 32'h3);
        bus(1'b1, OFS_IRQ_MASK, 32'h0, rd);
        irqchk(1'b0);
        bus(1'b1, OFS_IRQ_MASK, 32'h2, rd);
        irqchk(1'b1);
        bus(1'b1, OFS_IRQ_STAT, 32'h2, rd);
        irqchk(1'b0);
        rdchk("irq_status", OFS_IRQ_STAT, 32'h1);
        $display("test overrun_irq done");
        tx.send_frame(8'h00, 1'b1, PAR_NONE, 1'b0, 1'b1);
        bus(1'b1, OFS_MODE, mode_val(1'b0, PAR_NONE, 1'b1, 1'b0), rd);
        rdchk("rx_error_status", OFS_ERR, 32'h0);
        set_mode(PAR_NONE, 1'b1, 1'b0);
        tx.send_frame(8'h00, 1'b1, PAR_NONE, 1'b0, 1'b1);
        bus(1'b1, OFS_MODE, 32'h0, rd);
        rdchk("rx_error_status", OFS_ERR, 32'h0);
        rdchk("rx_data_buffer", OFS_DATA, 32'hFF);
        $display("test disable_clears done");
        stop_test;
    end
endmodule : uart_rx_error_status_test

// [dv/ures_uart_tx.sv]
// remote transmitter driving the receive line
module ures_uart_tx (
    // clock and serial line
    input  wire logic clk,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT_CLKS = 16; // divisor 0: one tick a clock
    initial rxd = 1'b1;
    // hold one bit for a full bit time
    task automatic put_bit(input logic v);
        rxd <= v;
        repeat (BIT_CLKS) @(posedge clk);
    endtask : put_bit
    // start, data lsb first, optional parity, stop
    task automatic send_frame(input logic [7:0] d, input logic l8, input logic [1:0] pm,
                              input logic bp, input logic bs);
        logic [7:0] dm;
        logic       p;
        dm = l8 ? d : {1'b0, d[6:0]};
        p = (pm == 2'h1) ? 1'b0 : (pm == 2'h2) ? ~(^dm) : ^dm;
        @(posedge clk);
        put_bit(1'b0);
        for (int i = 0; i < (l8 ? 8 : 7); i++) begin
            put_bit(dm[i]);
        end
        if (pm != 2'h0) begin
            put_bit(p ^ bp);
        end
        if (bs) begin
            rxd <= 1'b0;
            repeat (12) @(posedge clk); // low over the stop sample only
        end
        put_bit(1'b1);
    endtask : send_frame
endmodule : ures_uart_tx

// [rtl/ures_pkg.sv]
// Function
// - A software read of the receive error status register clears it to zero, unless a frame completes in the same cycle, when it loads the new flags.
// - Reset leaves the receive error status register at all zeros.
// - The parity, framing and overrun flags clear when unit enable or receiver enable is 0.
// - Exactly three error flags, parity, framing and overrun, report a frame's status when it completes.
// - The error status register is read-only, a whole 3-bit value, and writes do nothing to it.
// - Parity is judged by the two-bit mode: 00 none, 01 zero, 10 odd, 11 even.
// - A reception error raises the error interrupt if the select bit is 0, else the completion one.
// - On overrun the new frame is not moved into the receive data buffer.
package ures_pkg;
    // ***************************************
    // register map, byte addresses
    // ***************************************
    localparam int          ADDR_W        = 5;
    localparam logic [4:0]  OFS_MODE      = 5'h00;
    localparam logic [4:0]  OFS_ERR       = 5'h04;
    localparam logic [4:0]  OFS_DATA      = 5'h08;
    localparam logic [4:0]  OFS_BAUD      = 5'h0C;
    localparam logic [4:0]  OFS_IRQ_STAT  = 5'h10;
    localparam logic [4:0]  OFS_IRQ_MASK  = 5'h14;
    // ***************************************
    // serial_mode_control fields
    // ***************************************
    localparam int          MODE_UNIT_EN  = 7;
    localparam int          MODE_RX_EN    = 6;
    localparam int          MODE_PAR_HI   = 5;
    localparam int          MODE_PAR_LO   = 4;
    localparam int          MODE_LEN8     = 3;
    localparam int          MODE_IRQ_SEL  = 0;
    localparam logic [7:0]  MODE_RST      = 8'h00;
    // ***************************************
    // rx_error_status and irq fields
    // ***************************************
    localparam int          ERR_PARITY    = 2;
    localparam int          ERR_FRAMING   = 1;
    localparam int          ERR_OVERRUN   = 0;
    localparam logic [2:0]  ERR_RST       = 3'h0;
    localparam int          IRQ_COMPLETE  = 0;
    localparam int          IRQ_ERROR     = 1;
    localparam logic [1:0]  IRQ_RST       = 2'h0;
    localparam logic [7:0]  DATA_RST      = 8'hFF;
    localparam logic [15:0] BAUD_RST      = 16'h0003;
    // ***************************************
    // parity modes and frame timing
    // ***************************************
    localparam logic [1:0]  PAR_NONE      = 2'h0;
    localparam logic [1:0]  PAR_ZERO      = 2'h1;
    localparam logic [1:0]  PAR_ODD       = 2'h2;
    localparam logic [1:0]  PAR_EVEN      = 2'h3;
    localparam logic [3:0]  PHASE_MID     = 4'h7;
    localparam logic [3:0]  PHASE_LAST    = 4'hF;
    localparam logic [2:0]  LAST_BIT7     = 3'h6;
    localparam logic [2:0]  LAST_BIT8     = 3'h7;
endpackage : ures_pkg

// [rtl/ures_rx_frame.sv]
module ures_rx_frame
    import ures_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link to register core
    ures_rx_if.fsm   rx
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_DATA  = 3'b010,
        ST_PAR   = 3'b011,
        ST_STOP  = 3'b100
    } ures_rx_state_t;

    ures_rx_state_t state_r;
    logic [3:0]     phase_r;
    logic [2:0]     bit_r;
    logic [7:0]     shift_r;
    logic           pbit_r;
    logic           perr;
    logic           mid;
    logic           sample;
    logic [2:0]     last_bit;

    assign mid      = rx.tick && (phase_r == PHASE_MID);
    assign sample   = rx.tick && (phase_r == PHASE_LAST);
    assign last_bit = rx.len8 ? LAST_BIT8 : LAST_BIT7;

    // parity judgement by mode
    always_comb begin
        case (rx.parity_mode)
            PAR_ZERO: perr = pbit_r;
            PAR_ODD:  perr = ~(^shift_r ^ pbit_r);
            PAR_EVEN: perr = ^shift_r ^ pbit_r;
            default:  perr = 1'b0;
        endcase
    end

    // frame sequencer, 16 ticks per bit, sampled mid-bit
    always_ff @(posedge clk) begin
        if (rst || !rx.enable) begin
            state_r        <= ST_IDLE;
            phase_r        <= 4'h0;
            bit_r          <= 3'h0;
            shift_r        <= 8'h00;
            pbit_r         <= 1'b0;
            rx.done        <= 1'b0;
            rx.data        <= 8'h00;
            rx.parity_err  <= 1'b0;
            rx.framing_err <= 1'b0;
        end else begin
            rx.done <= 1'b0;
            if (rx.tick) begin
                phase_r <= phase_r + 4'h1;
            end
            case (state_r)
                ST_IDLE: begin
                    phase_r <= 4'h0;
                    if (!rx.rxd) begin
                        state_r <= ST_START;
                    end
                end
                ST_START: begin
                    if (mid) begin
                        // glitch rejection: line must still be low
                        state_r <= rx.rxd ? ST_IDLE : ST_DATA;
                        phase_r <= 4'h0;
                        bit_r   <= 3'h0;
                        shift_r <= 8'h00;
                    end
                end
                ST_DATA: begin
                    if (sample) begin
                        shift_r[bit_r] <= rx.rxd;
                        bit_r          <= bit_r + 3'h1;
                        if (bit_r == last_bit) begin
                            state_r <= (rx.parity_mode == PAR_NONE) ? ST_STOP : ST_PAR;
                        end
                    end
                end
                ST_PAR: begin
                    if (sample) begin
                        pbit_r  <= rx.rxd;
                        state_r <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (sample) begin
                        rx.done        <= 1'b1;
                        rx.data        <= shift_r;
                        rx.parity_err  <= perr;
                        rx.framing_err <= ~rx.rxd;
                        state_r        <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ***************************************
    // checks
    // ***************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_stop_low_frames: assert property (rx.enable && (state_r == ST_STOP) && sample && !rx.rxd
        |=> rx.done && rx.framing_err) else $error("low stop bit not flagged");
    a_no_parity_clean: assert property (rx.enable && (state_r == ST_STOP) && sample
        && (rx.parity_mode == PAR_NONE) |=> rx.done && !rx.parity_err)
        else $error("parity error without parity");
endmodule : ures_rx_frame

// [rtl/ures_rx_if.sv]
// frame engine link between register core and receiver
interface ures_rx_if;
    logic       enable;
    logic       tick;
    logic       len8;
    logic [1:0] parity_mode;
    logic       rxd;
    logic       done;
    logic [7:0] data;
    logic       parity_err;
    logic       framing_err;
    modport core (output enable, tick, len8, parity_mode, rxd,
                  input  done, data, parity_err, framing_err);
    modport fsm  (input  enable, tick, len8, parity_mode, rxd,
                  output done, data, parity_err, framing_err);
endinterface : ures_rx_if

// [rtl/ures_top.sv]
// Added by the designer: the address map and the Avalon-MM interface to the registers.
module ures_top
    import ures_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // serial line
    input  wire logic              rxd,
    // interrupts
    output logic                   rx_error_irq,
    output logic                   rx_complete_irq,
    output logic                   irq
);
    // ***************************************
    // state
    // ***************************************
    logic [7:0]  mode_r;
    logic [2:0]  err_r;
    logic [7:0]  rx_data_buffer_r;
    logic        buf_full_r;
    logic [15:0] baud_r;
    logic [15:0] div_r;
    logic [1:0]  irq_stat_r;
    logic [1:0]  irq_mask_r;
    logic        ack_r;
    logic        rxd_meta_r;
    logic        rxd_sync_r;
    logic        req;
    logic        rd_take;
    logic        wr_take;
    logic        wr_lane0;
    logic        unit_en;
    logic        rx_en;
    logic        dis_clr;
    logic [2:0]  new_err;
    logic        frame_err;
    logic        ev_error;
    logic        ev_complete;
    logic [7:0]  rd_mux;

    ures_rx_if rx_if ();

    ures_rx_frame u_frame (
        .clk (clk),
        .rst (rst),
        .rx  (rx_if)
    );

    // ***************************************
    // bus slave
    // ***************************************
    // one wait cycle: data is registered, then acknowledged
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_r;
    assign rd_take         = avs_read && !ack_r;
    assign wr_take         = avs_write && ack_r;
    assign wr_lane0        = wr_take && avs_byteenable[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    // read mux, narrow registers in the low bits
    always_comb begin
        case (avs_address)
            OFS_MODE:     rd_mux = mode_r;
            OFS_ERR:      rd_mux = {5'h00, err_r};
            OFS_DATA:     rd_mux = rx_data_buffer_r;
            OFS_IRQ_STAT: rd_mux = {6'h00, irq_stat_r};
            OFS_IRQ_MASK: rd_mux = {6'h00, irq_mask_r};
            default:      rd_mux = 8'h00;
        endcase
    end

    // read data captured in the wait cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_take) begin
            if (avs_address == OFS_BAUD) begin
                avs_readdata <= {16'h0000, baud_r};
            end else begin
                avs_readdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // ***************************************
    // configuration registers
    // ***************************************
    assign unit_en = mode_r[MODE_UNIT_EN];
    assign rx_en   = mode_r[MODE_RX_EN];
    assign dis_clr = !unit_en || !rx_en;

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r <= MODE_RST;
        end else if (wr_lane0 && (avs_address == OFS_MODE)) begin
            mode_r <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            baud_r <= BAUD_RST;
        end else if (wr_take && (avs_address == OFS_BAUD)) begin
            if (avs_byteenable[0]) begin
                baud_r[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                baud_r[15:8] <= avs_writedata[15:8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_r <= IRQ_RST;
        end else if (wr_lane0 && (avs_address == OFS_IRQ_MASK)) begin
            irq_mask_r <= avs_writedata[1:0];
        end
    end

    // ***************************************
    // line sync and oversampling divider
    // ***************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            rxd_meta_r <= 1'b1;
            rxd_sync_r <= 1'b1;
        end else begin
            rxd_meta_r <= rxd;
            rxd_sync_r <= rxd_meta_r;
        end
    end

    // one tick per baud_r+1 clocks, 16 ticks per bit
    always_ff @(posedge clk) begin
        if (rst || !unit_en || (div_r == baud_r)) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    assign rx_if.enable      = unit_en && rx_en;
    assign rx_if.tick        = unit_en && (div_r == baud_r);
    assign rx_if.len8        = mode_r[MODE_LEN8];
    assign rx_if.parity_mode = {mode_r[MODE_PAR_HI], mode_r[MODE_PAR_LO]};
    assign rx_if.rxd         = rxd_sync_r;

    // ***************************************
    // frame completion
    // ***************************************
    assign new_err[ERR_PARITY]  = rx_if.parity_err;
    assign new_err[ERR_FRAMING] = rx_if.framing_err;
    assign new_err[ERR_OVERRUN] = buf_full_r;
    assign frame_err   = rx_if.done && (new_err != ERR_RST);
    assign ev_error    = frame_err && !mode_r[MODE_IRQ_SEL];
    assign ev_complete = rx_if.done && (!frame_err || mode_r[MODE_IRQ_SEL]);

    // error flags: disable clears, new errors beat a read clear
    always_ff @(posedge clk) begin
        if (rst) begin
            err_r <= ERR_RST;
        end else if (dis_clr) begin
            err_r <= ERR_RST;
        end else if (rx_if.done) begin
            if (rd_take && (avs_address == OFS_ERR)) begin
                err_r <= new_err;
            end else begin
                err_r <= err_r | new_err;
            end
        end else if (rd_take && (avs_address == OFS_ERR)) begin
            err_r <= ERR_RST;
        end
    end

    // receive buffer, kept on overrun
    always_ff @(posedge clk) begin
        if (rst || !unit_en) begin
            rx_data_buffer_r <= DATA_RST;
        end else if (rx_if.done && !buf_full_r) begin
            rx_data_buffer_r <= rx_if.data;
        end
    end

    // unread marker, a completed frame wins over a read
    always_ff @(posedge clk) begin
        if (rst || !unit_en) begin
            buf_full_r <= 1'b0;
        end else if (rx_if.done) begin
            buf_full_r <= 1'b1;
        end else if (rd_take && (avs_address == OFS_DATA)) begin
            buf_full_r <= 1'b0;
        end
    end

    // ***************************************
    // interrupts
    // ***************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_error_irq    <= 1'b0;
            rx_complete_irq <= 1'b0;
        end else begin
            rx_error_irq    <= ev_error;
            rx_complete_irq <= ev_complete;
        end
    end

    // sticky status, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_r <= IRQ_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == IRQ_ERROR) ? ev_error : ev_complete) begin
                    irq_stat_r[i] <= 1'b1;
                end else if (wr_lane0 && (avs_address == OFS_IRQ_STAT) && avs_writedata[i]) begin
                    irq_stat_r[i] <= 1'b0;
                end
            end
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ***************************************
    // checks
    // ***************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_err_read;
        rd_take && (avs_address == OFS_ERR) && !rx_if.done;
    endsequence

    sequence s_err_write;
        avs_write && (avs_address == OFS_ERR) ##1 wr_take && !rx_if.done;
    endsequence

    a_read_clears_err: assert property (s_err_read |=> (err_r == ERR_RST) && !avs_waitrequest)
        else $error("status not cleared by read");
    a_reset_zero_err: assert property (disable iff (1'b0) rst |=> (err_r == ERR_RST))
        else $error("status not zero after reset");
    a_disable_clears: assert property (dis_clr |=> (err_r == ERR_RST) && !rx_if.done)
        else $error("flags set while disabled");
    a_three_flags: assert property (rd_take && (avs_address == OFS_ERR)
        |=> (avs_readdata[31:3] == 29'h0))
        else $error("status has more than three flags");
    a_flag_on_done: assert property ($rose(err_r[ERR_PARITY]) |-> $past(rx_if.done))
        else $error("parity flag set outside frame end");
    a_write_no_effect: assert property (s_err_write |=> $stable(err_r))
        else $error("status changed by write");
    a_irq_exclusive: assert property (!(rx_error_irq && rx_complete_irq))
        else $error("both receive interrupts raised");
    a_error_route: assert property (frame_err && !mode_r[MODE_IRQ_SEL]
        |=> rx_error_irq ##1 !rx_error_irq)
        else $error("error interrupt misrouted");
    a_overrun_keeps: assert property (rx_if.done && buf_full_r
        |=> $stable(rx_data_buffer_r) && err_r[ERR_OVERRUN])
        else $error("overrun frame overwrote buffer");

    // ***************************************
    // frame end routing, buffer and flag upkeep
    // ***************************************
    sequence s_clean_done;
        rx_if.done && (new_err == ERR_RST);
    endsequence

    a_read_keeps_new: assert property (rd_take && (avs_address == OFS_ERR) && rx_if.done && !dis_clr
        |=> (err_r == $past(new_err)))
        else $error("new flags lost on read clear");
    a_err_hold: assert property (!rx_if.done && !dis_clr && !(rd_take && (avs_address == OFS_ERR))
        |=> $stable(err_r))
        else $error("flags changed without an event");
    a_err_readback: assert property (rd_take && (avs_address == OFS_ERR)
        |=> (avs_readdata[2:0] == $past(err_r)))
        else $error("status read does not show flags");
    a_off_no_done: assert property (!rx_if.enable |=> !rx_if.done)
        else $error("frame completed while disabled");
    a_par_needs_mode: assert property (rx_if.done && rx_if.parity_err
        |-> (rx_if.parity_mode != PAR_NONE))
        else $error("parity error with parity off");
    a_clean_route: assert property (s_clean_done |=> rx_complete_irq && !rx_error_irq)
        else $error("clean frame not signalled as complete");
    a_select_route: assert property (rx_if.done && mode_r[MODE_IRQ_SEL]
        |=> rx_complete_irq && !rx_error_irq)
        else $error("selected error not routed to completion");
    a_buffer_takes: assert property (rx_if.done && !buf_full_r && unit_en
        |=> (rx_data_buffer_r == $past(rx_if.data)))
        else $error("received data not stored");
    a_framing_kept: assert property (rx_if.done && rx_if.framing_err && !dis_clr
        |=> err_r[ERR_FRAMING])
        else $error("framing flag not raised");
    a_unread_set: assert property (rx_if.done && unit_en |=> buf_full_r)
        else $error("unread marker not set");
endmodule : ures_top
